/* File: hw/mmbc_pkg.sv */
// Shared types and constants of the minimum-mode bus control block.
// Assumes one core clock; every T-state spans two core clock cycles.
package mmbc_pkg;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    KIND_MEM_RD,
    KIND_MEM_WR,
    KIND_IO_RD,
    KIND_IO_WR,
    KIND_INT_ACK
  } mmbc_kind_t;

  typedef enum logic [2:0] {
    ST_TI,
    ST_T1,
    ST_T2,
    ST_T3,
    ST_TW,
    ST_T4,
    ST_HOLD
  } mmbc_state_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Control lines that float during hold grant
  typedef struct packed {
    logic memIoSel;
    logic wrStrobeN;
    logic xcvrDirection;
    logic xcvrEnableN;
  } mmbc_ctl_t;

  typedef struct packed {
    mmbc_kind_t kind;
  } mmbc_req_t;

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  // First half of a T-state is clock high, second half clock low
  localparam logic PH_FIRST  = 1'h0;
  localparam logic PH_SECOND = 1'h1;

  localparam logic [3:0] CTL_RESET     = 4'hD;
  localparam logic [3:0] CTL_FLOAT_VAL = 4'hF;
  localparam logic       RST_PHASE     = 1'h0;
  localparam logic       RST_ALE       = 1'h0;
  localparam logic       RST_INT_ACK_STROBE_N_N    = 1'h1;
  localparam logic       RST_OE_N      = 1'h0;
  localparam logic       RST_GRANT     = 1'h0;
  localparam mmbc_kind_t RST_KIND      = KIND_MEM_RD;

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function automatic logic isWrite(input mmbc_kind_t k);
    isWrite = (k == KIND_MEM_WR) || (k == KIND_IO_WR);
  endfunction

  function automatic logic isMem(input mmbc_kind_t k);
    isMem = (k == KIND_MEM_RD) || (k == KIND_MEM_WR);
  endfunction

endpackage

/* File: hw/mmbc_strobe_gen.sv */
// Registered bus control strobes derived from the next sequencer state.
// Assumes its inputs are the next-cycle values, so pins line up with state.
`timescale 1ns/1ns
module mmbc_strobe_gen (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire mmbc_pkg::mmbc_state_t stateNxt,
  input  wire logic                phaseNxt,
  input  wire mmbc_pkg::mmbc_kind_t  kindNxt,
  input  wire logic                floatNxt,
  output mmbc_pkg::mmbc_ctl_t      ctlOut,
  output logic                     ctlOeN,
  output logic                     addrLatch,
  output logic                     int_ack_strobe_n
);
  import mmbc_pkg::*;

  mmbc_ctl_t ctl_r, ctl_nxt;
  logic      oeN_r, oeN_nxt;
  logic      ale_r, ale_nxt;
  logic      int_ack_strobe_n_r, int_ack_strobe_n_nxt;
  logic      strobeSpan;

  always_comb
  begin
    strobeSpan = (stateNxt == ST_T2) || (stateNxt == ST_T3) ||
                 (stateNxt == ST_TW);
    ctl_nxt.memIoSel = isMem(kindNxt);
    ctl_nxt.xcvrDirection = isWrite(kindNxt);
    ctl_nxt.wrStrobeN = !(strobeSpan && isWrite(kindNxt));
    // read opens mid T2, write at T2 start
    ctl_nxt.xcvrEnableN = !(
      (stateNxt == ST_T3) || (stateNxt == ST_TW) ||
      (stateNxt == ST_T4 && phaseNxt == PH_FIRST) ||
      (stateNxt == ST_T2 &&
       (isWrite(kindNxt) || phaseNxt == PH_SECOND)));
    // floated lines rest at weak one
    if (floatNxt)
    begin
      ctl_nxt = mmbc_ctl_t'(CTL_FLOAT_VAL);
    end
    oeN_nxt = floatNxt;
    // latch pulse in clock low of T1
    ale_nxt = (stateNxt == ST_T1) && (phaseNxt == PH_SECOND);
    int_ack_strobe_n_nxt = !(strobeSpan && kindNxt == KIND_INT_ACK);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_r  <= mmbc_ctl_t'(CTL_RESET);
      oeN_r  <= RST_OE_N;
      ale_r  <= RST_ALE;
      int_ack_strobe_n_r <= RST_INT_ACK_STROBE_N_N;
    end
    else
    begin
      ctl_r  <= ctl_nxt;
      oeN_r  <= oeN_nxt;
      ale_r  <= ale_nxt;
      int_ack_strobe_n_r <= int_ack_strobe_n_nxt;
    end
  end

  assign ctlOut           = ctl_r;
  assign ctlOeN           = oeN_r;
  assign addrLatch        = ale_r;
  assign int_ack_strobe_n = int_ack_strobe_n_r;

endmodule

/* File: hw/mmbc_hold_arb.sv */
// Hold request arbitration: grant register and bus float flag.
// Assumes holdReq already meets setup to core_clk.
`timescale 1ns/1ns
module mmbc_hold_arb (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic                holdReq,
  input  wire mmbc_pkg::mmbc_state_t stateR,
  input  wire logic                phaseR,
  input  wire logic                accept,
  output logic                     takeHold,
  output logic                     dropHold,
  output logic                     floatNxt,
  output logic                     grantR
);
  import mmbc_pkg::*;

  logic grant_r, grant_nxt;
  logic float_r;

  always_comb
  begin
    // grant rises at middle of T4 or TI
    takeHold = holdReq && !grant_r && phaseR == PH_FIRST &&
               (stateR == ST_T4 || stateR == ST_TI);
    dropHold = grant_r && !holdReq && phaseR == PH_FIRST &&
               stateR == ST_HOLD;
    grant_nxt = grant_r;
    if (takeHold)
    begin
      grant_nxt = 1'b1;
    end
    else if (dropHold)
    begin
      grant_nxt = 1'b0;
    end
    // float with grant, drive again on next cycle
    floatNxt = float_r;
    if (takeHold)
    begin
      floatNxt = 1'b1;
    end
    else if (accept)
    begin
      floatNxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      grant_r <= RST_GRANT;
      float_r <= RST_OE_N;
    end
    else
    begin
      grant_r <= grant_nxt;
      float_r <= floatNxt;
    end
  end

  assign grantR = grant_r;

endmodule

/* File: hw/mmbc_bus_ctl.sv */
// Minimum-mode local bus control: cycle sequencer, strobes, hold hand-over.
// Assumes hold and ready inputs are already timed to core_clk.
//
// Behaviour
// - Memory/IO select high for memory, low for IO, valid from prior T4 or TI.
// - Write strobe low during T2, T3 and TW of write cycles.
// - Acknowledge strobe low during T2, T3 and TW of acknowledge cycles.
// - Address latch pulses high in the clock-low half of T1.
// - Direction high when transmitting, low receiving, timed like select.
// - Transceiver enable active only in memory, IO and acknowledge cycles.
// - Read or acknowledge: enable from middle of T2 to middle of T4.
// - Write: enable from start of T2 to middle of T4.
// - High hold request answered by grant in middle of T4 or TI.
// - With grant, select, write, direction and enable float at weak one.
// - Low hold request drops grant; lines driven again at next cycle.
// - Address latch and acknowledge strobe are always driven.
// - Ready high from the target completes transfer; it is not synchronised.
`timescale 1ns/1ns
module mmbc_bus_ctl (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic                reqValid,
  input  wire mmbc_pkg::mmbc_req_t reqData,
  output logic                     reqReady,
  output logic                     cycleDone,
  input  wire logic                readyIn,
  input  wire logic                holdReq,
  output logic                     bus_hold_grant,
  output logic                     memIoSel,
  output logic                     wrStrobeN,
  output logic                     xcvr_direction,
  output logic                     xcvr_enable_n,
  output logic                     ctlOeN,
  output logic                     addrLatch,
  output logic                     int_ack_strobe_n,
  output mmbc_pkg::mmbc_state_t    busState
);
  import mmbc_pkg::*;

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  mmbc_state_t state_r, state_nxt;
  logic        phase_r, phase_nxt;
  mmbc_kind_t  kind_r, kind_nxt;
  logic        pend_r, pend_nxt;
  logic        done_r, done_nxt;
  logic        accept;
  logic        takeHold;
  logic        dropHold;
  logic        floatNxt;
  logic        grantR;
  mmbc_ctl_t   ctlPins;

  always_comb
  begin
    // Each T-state is two core clock cycles
    phase_nxt = !phase_r;
    // Hold wins over a new cycle at the same boundary
    accept = reqValid && !pend_r && !takeHold && !grantR &&
             phase_r == PH_FIRST &&
             (state_r == ST_T4 || state_r == ST_TI);
    // kind latched in T4 or TI before the cycle
    kind_nxt  = accept ? reqData.kind : kind_r;
    pend_nxt  = pend_r || accept;
    state_nxt = state_r;
    done_nxt  = 1'b0;
    if (phase_r == PH_SECOND)
    begin
      case (state_r)
        ST_TI:
        begin
          if (grantR)
          begin
            state_nxt = ST_HOLD;
          end
          else if (pend_r)
          begin
            state_nxt = ST_T1;
          end
        end
        ST_T1:
        begin
          state_nxt = ST_T2;
          pend_nxt  = 1'b0;
        end
        ST_T2:
        begin
          state_nxt = ST_T3;
        end
        ST_T3, ST_TW:
        begin
          state_nxt = readyIn ? ST_T4 : ST_TW;
        end
        ST_T4:
        begin
          done_nxt = 1'b1;
          if (grantR)
          begin
            state_nxt = ST_HOLD;
          end
          else if (pend_r)
          begin
            state_nxt = ST_T1;
          end
          else
          begin
            state_nxt = ST_TI;
          end
        end
        ST_HOLD:
        begin
          if (!grantR)
          begin
            state_nxt = ST_TI;
          end
        end
        default:
        begin
          state_nxt = ST_TI;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_TI;
      phase_r <= RST_PHASE;
      kind_r  <= RST_KIND;
      pend_r  <= 1'b0;
      done_r  <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      kind_r  <= kind_nxt;
      pend_r  <= pend_nxt;
      done_r  <= done_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Hold hand-over and pin strobes
  // ----------------------------------------------------------------
  // no synchroniser on the hold request
  mmbc_hold_arb uHold (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .holdReq  (holdReq),
    .stateR   (state_r),
    .phaseR   (phase_r),
    .accept   (accept),
    .takeHold (takeHold),
    .dropHold (dropHold),
    .floatNxt (floatNxt),
    .grantR   (grantR)
  );

  mmbc_strobe_gen uStrobe (
    .core_clk         (core_clk),
    .rst_n            (rst_n),
    .stateNxt         (state_nxt),
    .phaseNxt         (phase_nxt),
    .kindNxt          (kind_nxt),
    .floatNxt         (floatNxt),
    .ctlOut           (ctlPins),
    .ctlOeN           (ctlOeN),
    .addrLatch        (addrLatch),
    .int_ack_strobe_n (int_ack_strobe_n)
  );

  assign reqReady       = accept;
  assign cycleDone      = done_r;
  assign busState       = state_r;
  assign bus_hold_grant = grantR;
  assign memIoSel       = ctlPins.memIoSel;
  assign wrStrobeN      = ctlPins.wrStrobeN;
  assign xcvr_direction = ctlPins.xcvrDirection;
  assign xcvr_enable_n  = ctlPins.xcvrEnableN;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence seqStrobeSpan(logic s);
    !s [*4];
  endsequence

  sequence seqT2Start;
    state_r == ST_T2 && phase_r == PH_FIRST;
  endsequence

  AST_MEMIO_STABLE: assert property (
    (state_r inside {ST_T1, ST_T2, ST_T3, ST_TW}) && !ctlOeN
    |=> $stable(memIoSel))
    else $error("select changed inside a bus cycle");

  AST_WR_SPAN: assert property (
    $fell(wrStrobeN) |-> seqT2Start ##0 seqStrobeSpan(wrStrobeN))
    else $error("write strobe not held from T2 start");

  AST_INT_ACK_STROBE_N_SPAN: assert property (
    $fell(int_ack_strobe_n) |-> seqT2Start ##0
    seqStrobeSpan(int_ack_strobe_n))
    else $error("acknowledge strobe not held from T2 start");

  AST_ALE_PULSE: assert property (
    $rose(addrLatch) |-> state_r == ST_T1 && phase_r == PH_SECOND
    ##1 !addrLatch [*4])
    else $error("latch pulse outside T1 low half");

  AST_DIR_STABLE: assert property (
    !xcvr_enable_n |-> xcvr_direction == isWrite(kind_r))
    else $error("direction wrong while enabled");

  AST_DEN_INSIDE: assert property (
    !xcvr_enable_n |-> state_r inside {ST_T2, ST_T3, ST_TW, ST_T4})
    else $error("transceiver enabled outside a bus cycle");

  AST_DEN_READ: assert property (
    $fell(xcvr_enable_n) && !isWrite(kind_r)
    |-> state_r == ST_T2 && phase_r == PH_SECOND)
    else $error("read enable not at middle of T2");

  AST_DEN_WRITE: assert property (
    $fell(xcvr_enable_n) && isWrite(kind_r) |-> seqT2Start)
    else $error("write enable not at start of T2");

  AST_DEN_END: assert property (
    $rose(xcvr_enable_n) |-> state_r == ST_T4 && phase_r == PH_SECOND)
    else $error("enable not ended at middle of T4");

  AST_GRANT_MID: assert property (
    $rose(bus_hold_grant) |-> phase_r == PH_SECOND &&
    (state_r == ST_T4 || state_r == ST_TI))
    else $error("grant raised outside middle of T4 or TI");

  AST_FLOAT_GRANT: assert property (
    bus_hold_grant |-> ctlOeN && memIoSel && wrStrobeN &&
    xcvr_direction && xcvr_enable_n)
    else $error("control lines driven during grant");

  AST_RELEASE: assert property (
    state_r == ST_HOLD && phase_r == PH_FIRST && bus_hold_grant &&
    !holdReq |=> !bus_hold_grant)
    else $error("grant not dropped after request fell");

  AST_WAIT: assert property (
    state_r == ST_T3 && phase_r == PH_SECOND && !readyIn
    |=> state_r == ST_TW ##2 state_r inside {ST_TW, ST_T4})
    else $error("wait state not inserted");

  sequence seqCycleFront;
    seqT2Start ##1 state_r == ST_T2 ##1 state_r == ST_T3 ##1
    state_r == ST_T3;
  endsequence

  AST_FRONT_ORDER: assert property (
    state_r == ST_T1 && phase_r == PH_SECOND |=> seqCycleFront)
    else $error("cycle did not run T1 T2 T3 in order");

  AST_DONE_AFTER_T4: assert property (
    cycleDone |-> $past(state_r) == ST_T4)
    else $error("done pulse not right after T4");

  AST_MEMIO_KIND: assert property (
    (state_r inside {ST_T1, ST_T2, ST_T3, ST_TW}) && !ctlOeN
    |-> memIoSel == isMem(kind_r))
    else $error("select level does not match cycle kind");

  AST_WR_END: assert property (
    $rose(wrStrobeN) |-> state_r == ST_T4 && phase_r == PH_FIRST)
    else $error("write strobe not ended at T4 start");

  AST_INT_ACK_STROBE_N_END: assert property (
    $rose(int_ack_strobe_n) |-> state_r == ST_T4 && phase_r == PH_FIRST)
    else $error("acknowledge strobe not ended at T4 start");

  AST_ALE_ONLY_T1: assert property (
    addrLatch |-> state_r == ST_T1 && phase_r == PH_SECOND)
    else $error("latch pulse high outside T1 low half");

  AST_GRANT_FALL: assert property (
    $fell(bus_hold_grant) |-> state_r == ST_HOLD &&
    phase_r == PH_SECOND && $past(dropHold))
    else $error("grant dropped outside hold state");

  AST_FLOAT_KEEP: assert property (
    ctlOeN && !reqReady |=> ctlOeN)
    else $error("control lines driven again without a cycle");

  AST_ALWAYS_DRIVEN: assert property (
    bus_hold_grant |-> !addrLatch && int_ack_strobe_n)
    else $error("latch or acknowledge active during grant");

endmodule

/* File: verification/mmbc_far_model.sv */
// Far-side target model: answers each transfer with ready after waits.
// Assumes busState is the sequencer state and waitCnt is stable per cycle.
`timescale 1ns/1ns
module mmbc_far_model (
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire mmbc_pkg::mmbc_state_t busState,
  input  wire logic [3:0]            waitCnt,
  output logic                       readyIn
);
  import mmbc_pkg::*;

  logic [4:0] slowCnt;

  // ready ends transfer
  // Falling edge drive keeps setup to the sampling edge without a sync
  always @(negedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slowCnt <= 5'h00;
      readyIn <= 1'h0;
    end
    else if (busState == ST_T3 || busState == ST_TW)
    begin
      readyIn <= (slowCnt >= {waitCnt, 1'h1});
      slowCnt <= slowCnt + 5'h01;
    end
    else
    begin
      slowCnt <= 5'h00;
      readyIn <= 1'h0;
    end
  end
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for the minimum-mode bus control block.
// Assumes inputs change on the falling edge and outputs are read there.
`timescale 1ns/1ns
module tb_top;
  import mmbc_pkg::*;

  logic        core_clk;
  logic        rst_n;
  logic        reqValid;
  mmbc_req_t   reqData;
  logic        reqReady;
  logic        cycleDone;
  logic        readyIn;
  logic        holdReq;
  logic        grant;
  logic        memIoSel;
  logic        wrStrobeN;
  logic        xcvrDir;
  logic        xcvrEnN;
  logic        ctlOeN;
  logic        addrLatch;
  logic        intaN;
  mmbc_state_t busState;
  logic [3:0]  waitCnt;
  int          fails;
  int          checks;
  bit          chainPrev;

  mmbc_bus_ctl i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .reqValid(reqValid),
    .reqData(reqData), .reqReady(reqReady), .cycleDone(cycleDone),
    .readyIn(readyIn), .holdReq(holdReq), .bus_hold_grant(grant),
    .memIoSel(memIoSel), .wrStrobeN(wrStrobeN),
    .xcvr_direction(xcvrDir), .xcvr_enable_n(xcvrEnN), .ctlOeN(ctlOeN),
    .addrLatch(addrLatch), .int_ack_strobe_n(intaN), .busState(busState)
  );

  mmbc_far_model i_far (
    .core_clk(core_clk), .rst_n(rst_n), .busState(busState),
    .waitCnt(waitCnt), .readyIn(readyIn)
  );

  initial
  begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [3:0] seen,
                       input logic [3:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("Counts: checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic do_reset;
    rst_n = 1'h0;
    chainPrev = 1'b0;
    repeat (20) @(negedge core_clk);
    check("memIoSel", memIoSel, 1'h1);
    check("ctlOeN", ctlOeN, 1'h0);
    check("strobes", {wrStrobeN, xcvrEnN, intaN, xcvrDir}, 4'hE);
    check("grant", grant, 1'h0);
    check("busState", busState, ST_TI);
    check("cycleDone", cycleDone, 1'h0);
    rst_n = 1'h1;
    @(negedge core_clk);
    $display("reset test done");
  endtask

  // One bus cycle; keep chains the next request, holdAt raises hold
  task automatic run_cycle(input mmbc_kind_t kind, input int w,
                           input bit keep, input int holdAt);
    int   i;
    int   n;
    int   last;
    logic wr;
    logic ack;
    logic flt;
    logic act;
    bit   prev;
    wr = (kind == KIND_MEM_WR) || (kind == KIND_IO_WR);
    ack = (kind == KIND_INT_ACK);
    // Chained call still sees the done pulse of the cycle before
    prev = chainPrev;
    chainPrev = keep;
    last = keep ? 8 + 2 * w : 10 + 2 * w;
    waitCnt = w[3:0];
    reqData.kind = kind;
    reqValid = 1'h1;
    n = 0;
    #1;
    while (reqReady !== 1'h1 && n < 40)
    begin
      @(negedge core_clk);
      #1;
      n++;
    end
    check("reqReady", reqReady, 1'h1);
    @(negedge core_clk);
    if (!keep)
      reqValid = 1'h0;
    for (i = 1; i <= last; i++)
    begin
      if (i == holdAt)
        holdReq = 1'h1;
      flt = (holdAt > 0) && (i >= 9 + 2 * w);
      act = (i >= 4) && (i <= 7 + 2 * w);
      check("memIoSel", memIoSel,
            flt | (kind == KIND_MEM_RD) | (kind == KIND_MEM_WR));
      check("wrStrobeN", wrStrobeN, flt | !(wr && act));
      check("intAck", intaN, !(ack && act));
      check("addrLatch", addrLatch, i == 3);
      check("xcvrDir", xcvrDir, flt | wr);
      check("xcvrEnN", xcvrEnN, flt | !((i >= (wr ? 4 : 5))
            && (i <= 8 + 2 * w)));
      check("ctlOeN", ctlOeN, flt);
      check("grant", grant, flt);
      check("cycleDone", cycleDone,
            (i == 10 + 2 * w) || (prev && i == 2));
      if (keep && i == last)
        check("chainReady", reqReady, 1'h1);
      if (i < last)
        @(negedge core_clk);
    end
    $display("cycle test done kind %0d waits %0d", kind, w);
  endtask

  // Hold already granted: refuse requests, release, stay floated
  task automatic hold_release;
    int n;
    reqData.kind = KIND_IO_RD;
    reqValid = 1'h1;
    repeat (6)
    begin
      @(negedge core_clk);
      check("holdRefuse", reqReady, 1'h0);
      check("holdFloat", {ctlOeN, memIoSel, xcvrDir}, 4'h7);
      check("driven", {addrLatch, intaN}, 4'h1);
    end
    reqValid = 1'h0;
    holdReq = 1'h0;
    n = 0;
    while (grant !== 1'h0 && n < 8)
    begin
      @(negedge core_clk);
      n++;
    end
    check("grantDrop", grant, 1'h0);
    repeat (4)
    begin
      @(negedge core_clk);
      check("stayFloat", ctlOeN, 1'h1);
    end
    run_cycle(KIND_IO_RD, 0, 0, 0);
    $display("hold release test done");
  endtask

  task automatic hold_idle;
    int n;
    holdReq = 1'h1;
    n = 0;
    while (grant !== 1'h1 && n < 4)
    begin
      @(negedge core_clk);
      n++;
    end
    check("idleGrant", grant, 1'h1);
    hold_release();
    $display("idle hold test done");
  endtask

  initial
  begin
    rst_n = 1'h0;
    reqValid = 1'h0;
    reqData.kind = KIND_MEM_RD;
    holdReq = 1'h0;
    waitCnt = 4'h0;
    fails = 0;
    checks = 0;
    @(negedge core_clk);
    do_reset();
    for (int k = 0; k < 5; k++)
    begin
      run_cycle(mmbc_kind_t'(k), 0, 0, 0);
      run_cycle(mmbc_kind_t'(k), 2, 0, 0);
    end
    run_cycle(KIND_MEM_WR, 1, 1, 0);
    run_cycle(KIND_INT_ACK, 0, 1, 0);
    run_cycle(KIND_IO_WR, 0, 0, 0);
    run_cycle(KIND_MEM_WR, 0, 0, 4);
    hold_release();
    hold_idle();
    do_reset();
    run_cycle(KIND_INT_ACK, 1, 0, 0);
    give_verdict();
  end

  // Whole run needs a few hundred cycles; this is far beyond
  initial
  begin
    #1000000;
    $display("watchdog expired");
    fails++;
    give_verdict();
  end
endmodule
